// ---- include/ersw_pkg.sv ----
// package for the error report second-word builder
// assumes a single pclk domain and an apb register bus
package ersw_pkg;
  // register byte offsets
  localparam logic [11:0] ERSW_CTRL_OFF = 12'h000;
  localparam logic [11:0] ERSW_SRC_OFF = 12'h004;
  localparam logic [11:0] ERSW_EVT_OFF = 12'h008;
  localparam logic [11:0] ERSW_WORD_OFF = 12'h00c;
  localparam logic [11:0] ERSW_STAT_OFF = 12'h010;
  localparam logic [11:0] ERSW_MASK_OFF = 12'h014;
  // second word field positions
  localparam int ERSW_SRC_LSB = 0;
  localparam int ERSW_PORT_LSB = 8;
  localparam int ERSW_TYPE_LSB = 12;
  localparam int ERSW_UE_BIT = 16;
  localparam int ERSW_NOCOMM_BIT = 17;
  localparam int ERSW_DEGR_BIT = 18;
  localparam int ERSW_DEFER_BIT = 19;
  // control register fields
  localparam int ERSW_CTL_DEGR_BIT = 0;
  localparam int ERSW_CTL_THR_LSB = 8;
  // event register fields (write launches a report)
  localparam int ERSW_EVT_TYPE_LSB = 0;
  localparam int ERSW_EVT_AGENT_LSB = 4;
  localparam int ERSW_EVT_PORT_LSB = 12;
  localparam int ERSW_EVT_UE_BIT = 16;
  localparam int ERSW_EVT_UNSAFE_BIT = 17;
  localparam int ERSW_EVT_DEFER_BIT = 18;
  localparam int ERSW_EVT_LOST_BIT = 19;
  localparam int ERSW_EVT_CRIT_BIT = 20;
  // status and mask bits
  localparam int ERSW_ST_SENT_BIT = 0;
  localparam int ERSW_ST_BAD_BIT = 1;
  localparam int ERSW_ST_DROP_BIT = 2;
  // reset values
  localparam logic [31:0] ERSW_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] ERSW_DEVID_RST = 8'h00;
  localparam logic [7:0] ERSW_THR_RST = 8'h00;
  // component type codes
  localparam logic [3:0] ERSW_T_RA = 4'h0;
  localparam logic [3:0] ERSW_T_HA = 4'h1;
  localparam logic [3:0] ERSW_T_SA = 4'h2;
  localparam logic [3:0] ERSW_T_PORT = 4'h3;
  localparam logic [3:0] ERSW_T_LINK = 4'h4;
  // builder states
  typedef enum logic [1:0] {ERSW_IDLE, ERSW_SEND} ersw_state_t;
endpackage

// ---- include/ersw_evt_if.sv ----
// interface carrying one error event from the register file to the word builder
// assumes both ends run on pclk
`timescale 1ns/10ps
`default_nettype none
interface ersw_evt_if;
  logic valid; // one-cycle event strobe
  logic [3:0] comp_type; // reporting component type
  logic [5:0] agent; // agent identifier
  logic [3:0] port; // port index
  logic ue; // uncorrected
  logic unsafe; // communication broken
  logic defer; // detected, not consumed
  logic lost; // an uncorrected error was dropped
  logic degraded; // reduced reliability
  logic [7:0] dev_id; // device identifier
  logic [31:0] word; // built word
  logic bad_type; // reserved type requested
  modport src (output valid, comp_type, agent, port, ue, unsafe, defer, lost,
    degraded, dev_id, input word, bad_type);
  modport bld (input valid, comp_type, agent, port, ue, unsafe, defer, lost,
    degraded, dev_id, output word, bad_type);
endinterface
`default_nettype wire

// ---- src/ersw_build.sv ----
// combinational builder for the second word of an error report
// assumes inputs are stable while valid is high
`timescale 1ns/10ps
`default_nettype none
module ersw_build (
  // event in, word out
  ersw_evt_if.bld evt
);
  // agent-type reporters carry an agent identifier
  wire logic is_agent;
  wire logic is_port;
  wire logic type_ok;
  wire logic [7:0] src_id;
  wire logic [3:0] port_id;
  wire logic [3:0] type_code;
  wire logic nocomm;
  wire logic defer_v;
  assign is_agent = (evt.comp_type == ersw_pkg::ERSW_T_RA) ||
    (evt.comp_type == ersw_pkg::ERSW_T_HA) || (evt.comp_type == ersw_pkg::ERSW_T_SA);
  assign is_port = (evt.comp_type == ersw_pkg::ERSW_T_PORT) ||
    (evt.comp_type == ersw_pkg::ERSW_T_LINK);
  assign type_ok = is_agent || is_port;
  // reserved types fall back to port so no reserved code leaves
  assign type_code = type_ok ? evt.comp_type : ersw_pkg::ERSW_T_PORT;
  // agent id in 5:0 with 7:6 zero, else device id
  assign src_id = is_agent ? {2'b00, evt.agent} : evt.dev_id;
  // port index for port, link and reserved types, zero for agent types
  assign port_id = is_agent ? 4'h0 : evt.port;
  // dropped uncorrected errors mean broken communication only when this event is uncorrected too
  assign nocomm = evt.ue & (evt.unsafe | evt.lost);
  // deferred only meaningful when not uncorrected
  assign defer_v = evt.defer & ~evt.ue;
  assign evt.bad_type = ~type_ok;
  assign evt.word = {8'h00, 4'h0, defer_v, evt.degraded, nocomm, evt.ue,
    type_code, port_id, src_id};
endmodule
`default_nettype wire

// ---- src/ersw_top.sv ----
// apb-controlled builder of the error report second word
// assumes an apb master on pclk; the report word goes out with a one-cycle strobe
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ersw_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // report word out
  output logic [31:0] report_word,
  output logic report_valid,
  // interrupt
  output logic irq
);
  ersw_evt_if evt (); // event path to the builder
  ersw_pkg::ersw_state_t state_q, state_d; // send sequencer
  logic [31:0] ctrl_q; // degraded force and ce threshold
  logic [7:0] dev_id_q; // device identifier
  logic [31:0] evt_q; // last event written
  logic evt_go_q; // event strobe into the builder
  logic [31:0] word_q; // last word built
  logic [2:0] stat_q; // sticky status
  logic [2:0] mask_q; // interrupt mask
  logic [7:0] ce_cnt_q; // corrected error count
  logic crit_q; // critical condition seen
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;
  logic [31:0] out_q;
  logic out_v_q;
  logic irq_q;
  // apb decode; access answered in the first access cycle
  wire logic acc;
  wire logic wr;
  wire logic rd;
  wire logic hit;
  wire logic [31:0] rd_mux;
  wire logic [2:0] ev_set;
  wire logic thr_hit;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit = (paddr == ersw_pkg::ERSW_CTRL_OFF) || (paddr == ersw_pkg::ERSW_SRC_OFF) ||
    (paddr == ersw_pkg::ERSW_EVT_OFF) || (paddr == ersw_pkg::ERSW_WORD_OFF) ||
    (paddr == ersw_pkg::ERSW_STAT_OFF) || (paddr == ersw_pkg::ERSW_MASK_OFF);
  assign rd_mux = (paddr == ersw_pkg::ERSW_CTRL_OFF) ? ctrl_q :
    (paddr == ersw_pkg::ERSW_SRC_OFF) ? {24'h000000, dev_id_q} :
    (paddr == ersw_pkg::ERSW_EVT_OFF) ? evt_q :
    (paddr == ersw_pkg::ERSW_WORD_OFF) ? word_q :
    // an event in the setup cycle is shown now, since the read clear follows it
    (paddr == ersw_pkg::ERSW_STAT_OFF) ? {29'h0, stat_q | ev_set} :
    (paddr == ersw_pkg::ERSW_MASK_OFF) ? {29'h0, mask_q} : 32'h0000_0000;
  // threshold reached puts the device in degraded mode
  assign thr_hit = (ctrl_q[ersw_pkg::ERSW_CTL_THR_LSB +: 8] != 8'h00) &&
    (ce_cnt_q >= ctrl_q[ersw_pkg::ERSW_CTL_THR_LSB +: 8]);
  // event fields toward the builder
  assign evt.valid = evt_go_q;
  assign evt.comp_type = evt_q[ersw_pkg::ERSW_EVT_TYPE_LSB +: 4];
  assign evt.agent = evt_q[ersw_pkg::ERSW_EVT_AGENT_LSB +: 6];
  assign evt.port = evt_q[ersw_pkg::ERSW_EVT_PORT_LSB +: 4];
  assign evt.ue = evt_q[ersw_pkg::ERSW_EVT_UE_BIT];
  assign evt.unsafe = evt_q[ersw_pkg::ERSW_EVT_UNSAFE_BIT];
  assign evt.defer = evt_q[ersw_pkg::ERSW_EVT_DEFER_BIT];
  assign evt.lost = evt_q[ersw_pkg::ERSW_EVT_LOST_BIT];
  // degraded when forced, threshold met or critical seen
  assign evt.degraded = ctrl_q[ersw_pkg::ERSW_CTL_DEGR_BIT] | thr_hit | crit_q;
  assign evt.dev_id = dev_id_q;
  // events: word sent, reserved type asked, uncorrected error dropped
  assign ev_set = {evt_go_q & evt.lost & evt.ue, evt_go_q & evt.bad_type, evt_go_q};
  ersw_build u_build (
    .evt(evt)
  );
  // sequencer: event write, then one send cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ersw_pkg::ERSW_IDLE: begin
        if (evt_go_q) begin
          state_d = ersw_pkg::ERSW_SEND;
        end
      end
      ersw_pkg::ERSW_SEND: begin
        state_d = ersw_pkg::ERSW_IDLE;
      end
      default: begin
        state_d = ersw_pkg::ERSW_IDLE;
      end
    endcase
  end
  // register writes and event launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ersw_pkg::ERSW_CTRL_RST;
      dev_id_q <= ersw_pkg::ERSW_DEVID_RST;
      evt_q <= 32'h0000_0000;
      mask_q <= 3'h0;
      evt_go_q <= 1'b0;
    end else begin
      evt_go_q <= wr && (paddr == ersw_pkg::ERSW_EVT_OFF);
      if (wr && (paddr == ersw_pkg::ERSW_CTRL_OFF)) begin
        ctrl_q <= pwdata & 32'h0000_ff01;
      end
      if (wr && (paddr == ersw_pkg::ERSW_SRC_OFF)) begin
        dev_id_q <= pwdata[7:0];
      end
      if (wr && (paddr == ersw_pkg::ERSW_EVT_OFF)) begin
        evt_q <= pwdata & 32'h001f_ffff;
      end
      if (wr && (paddr == ersw_pkg::ERSW_MASK_OFF)) begin
        mask_q <= pwdata[2:0];
      end
    end
  end
  // word capture, counters and output strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ersw_pkg::ERSW_IDLE;
      word_q <= 32'h0000_0000;
      out_q <= 32'h0000_0000;
      out_v_q <= 1'b0;
      ce_cnt_q <= 8'h00;
      crit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_v_q <= (state_q == ersw_pkg::ERSW_IDLE) && evt_go_q;
      if (evt_go_q) begin
        word_q <= evt.word;
        out_q <= evt.word;
        // corrected errors feed the threshold; saturate to avoid wrap
        if (!evt.ue && (ce_cnt_q != 8'hff)) begin
          ce_cnt_q <= ce_cnt_q + 8'h01;
        end
        if (evt_q[ersw_pkg::ERSW_EVT_CRIT_BIT]) begin
          crit_q <= 1'b1;
        end
      end
    end
  end
  // sticky status: set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
    end else if (rd && (paddr == ersw_pkg::ERSW_STAT_OFF)) begin
      stat_q <= ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end
  // apb answer and interrupt, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      irq_q <= |((stat_q | ev_set) & mask_q);
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign report_word = out_q;
  assign report_valid = out_v_q;
  assign irq = irq_q;
  // checks
  agent_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    report_valid && (report_word[15:12] <= 4'h2) |-> report_word[7:6] == 2'b00)
    else $error("agent source upper bits not zero");
  type_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    report_valid |-> report_word[15:12] <= 4'h4)
    else $error("reserved component type sent");
  port_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    report_valid && (report_word[15:12] <= 4'h2) |-> report_word[11:8] == 4'h0)
    else $error("invalid port index not zero");
  devid_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    report_valid && (report_word[15:12] >= 4'h3) |-> report_word[7:0] == dev_id_q)
    else $error("device identifier missing");
  lost_unsafe_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt_go_q && evt.ue && evt.lost |=> report_valid && report_word[17])
    else $error("lost uncorrected error without unsafe flag");
  ue_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt_go_q |=> report_valid && (report_word[16] == $past(evt.ue)))
    else $error("uncorrected flag wrong");
  defer_ue_a: assert property (@(posedge pclk) disable iff (!presetn)
    report_valid |-> !(report_word[19] && report_word[16]) && report_word[23:20] == 4'h0)
    else $error("deferred with uncorrected or reserved bits set");
  nocomm_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt_go_q && evt.ue && evt.unsafe |=> report_word[17])
    else $error("unsafe flag not set");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("apb answer late");
  port_cov: cover property (@(posedge pclk) disable iff (!presetn)
    report_valid && report_word[15:12] == 4'h3);
  lost_cov: cover property (@(posedge pclk) disable iff (!presetn)
    report_valid && report_word[17]);
  irq_cov: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule
`default_nettype wire

// ---- tb/ersw_host_model.sv ----
// host error agent model: takes in each report word as it is strobed out
// assumes report_valid is a one-cycle pulse on pclk and the host never stalls
`timescale 1ns/10ps
`default_nettype none
module ersw_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // report stream from the device
  input wire logic [31:0] report_word,
  input wire logic report_valid,
  // what the host made of the last report
  output logic [31:0] last_word,
  output logic [15:0] report_count,
  output logic port_ok,
  output logic unsafe_seen,
  output logic [11:0] bdf_key
);
  // type field of the incoming word
  wire logic [3:0] rx_type = report_word[15:12];
  // capture on the strobe only; a word outside it means nothing to the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_word <= 32'h0;
      report_count <= 16'h0;
      port_ok <= 1'b0;
      unsafe_seen <= 1'b0;
      bdf_key <= 12'h0;
    end else if (report_valid) begin
      last_word <= report_word;
      report_count <= report_count + 16'h1;
      port_ok <= (rx_type == 4'h3) || (rx_type == 4'h4);
      unsafe_seen <= report_word[16] & report_word[17];
      bdf_key <= {report_word[7:0], report_word[11:8]};
    end
  end
endmodule
`default_nettype wire

// ---- tb/error_report_source_severity_word_tb.sv ----
// self-checking bench for the error report word builder
// assumes zero-wait apb and a fixed report latency after an event write
`timescale 1ns/10ps
`default_nettype none
module error_report_source_severity_word_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, report_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, report_word, rd, got, ew;
  logic [31:0] last_word;
  logic [15:0] report_count;
  logic port_ok, unsafe_seen, er, deg;
  logic [7:0] dev;
  logic [11:0] bdf;
  logic [20:0] e;
  logic [20:0] corner [4] = '{21'h093ff0, 21'h051234, 21'h04a5f3, 21'h0301c2};
  int fail_count, samples_checked;
  integer seed = 32'hf17d;
  ersw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .report_word(report_word), .report_valid(report_valid), .irq(irq));
  ersw_host_model u_host (.pclk(pclk), .presetn(presetn), .report_word(report_word),
    .report_valid(report_valid), .last_word(last_word), .report_count(report_count),
    .port_ok(port_ok), .unsafe_seen(unsafe_seen), .bdf_key(bdf));
  // 125 MHz clock
  always #4 pclk = ~pclk;
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, entered just after a rising edge; idle edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) check("pready", 32'h0, 32'h1);
    @(posedge pclk);
  endtask
  // expected second word from the event fields
  function automatic logic [31:0] exp_word(input logic [20:0] v, input logic [7:0] id,
    input logic dg);
    logic [3:0] t;
    logic ag;
    logic [31:0] w;
    t = (v[3:0] > 4'h4) ? 4'h3 : v[3:0];
    ag = t < 4'h3;
    w = 32'h0;
    w[7:0] = ag ? {2'b00, v[9:4]} : id;
    w[11:8] = ag ? 4'h0 : v[15:12];
    w[15:12] = t;
    w[16] = v[16];
    w[17] = v[16] & (v[17] | v[19]);
    w[18] = dg;
    w[19] = v[18] & ~v[16];
    return w;
  endfunction
  // verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    deg = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset word", report_word, 32'h0);
    check("reset irq", {31'h0, irq}, 32'h0);
    $display("reset test done");
    dev = 8'($random(seed));
    apb(1'b1, ersw_pkg::ERSW_SRC_OFF, {24'h0, dev});
    for (int i = 0; i < 48; i++) begin
      e = 21'($random(seed));
      e[20] = (i == 44);
      if (i < 8) e[3:0] = i[3:0];
      if (i >= 8 && i < 12) e = corner[i - 8];
      apb(1'b1, ersw_pkg::ERSW_CTRL_OFF, {31'h0, i[2]});
      apb(1'b1, ersw_pkg::ERSW_MASK_OFF, {31'h0, i[0]});
      apb(1'b1, ersw_pkg::ERSW_EVT_OFF, {11'h0, e});
      repeat (4) @(posedge pclk);
      ew = exp_word(e, dev, i[2] | deg) | (e[20] ? 32'h40000 : 32'h0);
      got = last_word | (e[20] ? 32'h40000 : 32'h0);
      check("word", got, ew);
      check("port valid", {31'h0, port_ok}, {31'h0, ew[15:12] > 4'h2});
      check("unsafe", {31'h0, unsafe_seen}, {31'h0, e[16] & (e[17] | e[19])});
      check("irq", {31'h0, irq}, {31'h0, i[0]});
      check("bdf key", {20'h0, bdf}, {20'h0, ew[7:0], ew[11:8]});
      apb(1'b0, ersw_pkg::ERSW_WORD_OFF, 32'h0);
      check("word reg", rd | (e[20] ? 32'h40000 : 32'h0), ew);
      apb(1'b0, ersw_pkg::ERSW_STAT_OFF, 32'h0);
      check("status", rd & 32'h7, {29'h0, e[16] & e[19], e[3:0] > 4'h4, 1'b1});
      repeat (2) @(posedge pclk);
      check("irq clear", {31'h0, irq}, 32'h0);
      deg = deg | e[20];
    end
    check("count", {16'h0, report_count}, 32'h0000_0030);
    $display("event test done");
    apb(1'b0, 12'h020, 32'h0);
    check("bad read", {rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h024, 32'h5);
    check("bad write", {31'h0, er}, 32'h1);
    $display("unmapped test done");
    wrap_up();
  end
endmodule
`default_nettype wire
